// *** gxip_pkg.sv ***
// package for the gpio and external interrupt pin logic
// Summary of operation
// - nonmaskable interrupt fires on a rising edge of its pin, never on level
// - after reset interrupt-capable pins are inputs with drivers off
// - enable bits 7..4 turn pins 7..4 into input-only interrupt inputs
// - interrupt inputs are edge triggered, edge picked per pin by polarity bits 3..0
// - pin 0 defaults input, may be output or interrupt output
// - pin 2 defaults to a one-sixth rate clock, else bidirectional gpio
// - pin 1 defaults to a one-quarter rate clock, else bidirectional gpio
package gxip_pkg;
  localparam int unsigned GXIP_NPINS = 8;
  // register byte offsets
  localparam logic [11:0] GXIP_OFF_DIR    = 12'h000; // gpio direction, 1 = output
  localparam logic [11:0] GXIP_OFF_OUT    = 12'h004; // gpio output data
  localparam logic [11:0] GXIP_OFF_IN     = 12'h008; // pin levels, read only
  localparam logic [11:0] GXIP_OFF_IEN    = 12'h00c; // irq enable bits [7:4]
  localparam logic [11:0] GXIP_OFF_POL    = 12'h010; // edge polarity [3:0]
  localparam logic [11:0] GXIP_OFF_MUX    = 12'h014; // pin function select
  localparam logic [11:0] GXIP_OFF_STAT   = 12'h018; // sticky events, write one to clear
  localparam logic [11:0] GXIP_OFF_MASK   = 12'h01c; // interrupt mask
  // mux register fields
  localparam int unsigned GXIP_MUX_P1_GPIO = 0;  // pin 1 gpio instead of clock
  localparam int unsigned GXIP_MUX_P2_GPIO = 1;  // pin 2 gpio instead of clock
  localparam int unsigned GXIP_MUX_P0_LO   = 2;  // pin 0 mode field [3:2]
  // status bits: [7:4] external interrupts, [8] nmi
  localparam int unsigned GXIP_STAT_NMI    = 8;
  localparam int unsigned GXIP_STAT_W      = 9;
  // reset values
  localparam logic [7:0]  GXIP_DIR_RST  = 8'h00;
  localparam logic [7:0]  GXIP_OUT_RST  = 8'h00;
  localparam logic [3:0]  GXIP_MUX_RST  = 4'h0;
  localparam logic [3:0]  GXIP_POL_RST  = 4'h0;
  // clock dividers, in core cycles per output period
  localparam int unsigned GXIP_DIV_QUARTER = 4;
  localparam int unsigned GXIP_DIV_SIXTH   = 6;
  typedef enum logic [1:0] {
    GXIP_P0_INPUT = 2'b00,
    GXIP_P0_GPOUT = 2'b01,
    GXIP_P0_IRQ   = 2'b10
  } gxip_p0_mode_t;
endpackage : gxip_pkg

// *** gxip_edge_if.sv ***
// interface carrying one synchronised pin between edge detectors and top
`timescale 1ns/1ns
interface gxip_edge_if;
  logic pin_sync; // synchronised level
  logic rise;     // one-cycle rising edge pulse
  logic fall;     // one-cycle falling edge pulse
  modport det (output pin_sync, output rise, output fall);
  modport use_side (input pin_sync, input rise, input fall);
endinterface : gxip_edge_if

// *** gxip_sync_edge.sv ***
// two-stage synchroniser with edge detector
`timescale 1ns/1ns
module gxip_sync_edge (
  input  wire logic clk_sys, // core clock
  input  wire logic rstn,    // async reset, active low
  input  wire logic ce,      // clock enable
  input  wire logic pin_in,  // raw pin level
  gxip_edge_if.det  eo       // synchronised level and edges
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // first stage read only by second stage
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else if (ce)
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // one pulse per edge, gated by ce so a frozen block sees none
  assign eo.pin_sync = s2_reg;
  assign eo.rise = ce & s2_reg & ~s3_reg;
  assign eo.fall = ce & ~s2_reg & s3_reg;
endmodule : gxip_sync_edge

// *** gxip_top.sv ***
// gpio bank with external interrupts, nmi, clock outputs and apb registers
`timescale 1ns/1ns
module gxip_top (
  input  wire logic                          clk_sys,     // core clock 125 MHz
  input  wire logic                          rstn,        // async reset, active low
  input  wire logic                          ce,          // clock enable, freezes state
  // apb slave
  input  wire logic                          psel,        // select
  input  wire logic                          penable,     // access phase
  input  wire logic                          pwrite,      // write when high
  input  wire logic [11:0]                   paddr,       // byte address
  input  wire logic [31:0]                   pwdata,      // write data
  output logic      [31:0]                   prdata,      // read data
  output logic                               pready,      // transfer done
  output logic                               pslverr,     // unmapped address
  // pins
  input  wire logic [gxip_pkg::GXIP_NPINS-1:0] gpio_bank_zero_i,  // pin levels
  output logic      [gxip_pkg::GXIP_NPINS-1:0] gpio_bank_zero_o,  // pin drive values
  output logic      [gxip_pkg::GXIP_NPINS-1:0] gpio_bank_zero_oe, // high while driving
  input  wire logic                          nmi_pin,     // nonmaskable interrupt pin
  output logic                               nmi_event,   // one-cycle nmi to core
  output logic                               irq          // level, unmasked status set
);
  import gxip_pkg::*;

  logic [7:0]            dir_reg;
  logic [7:0]            out_reg;
  logic [7:4]            ien_reg;
  logic [3:0]            pol_reg;
  logic [3:0]            mux_reg;
  logic [GXIP_STAT_W-1:0] stat_reg;
  logic [GXIP_STAT_W-1:0] stat_next;
  logic [GXIP_STAT_W-1:0] mask_reg;
  logic [1:0]            cnt4_reg;
  logic [2:0]            cnt6_reg;
  logic                  clk4_reg;
  logic                  clk6_reg;

  // synchronisers for the eight gpio pins plus nmi
  gxip_edge_if e_if [0:GXIP_NPINS] ();
  logic [GXIP_NPINS:0]   raw_in;
  logic [GXIP_NPINS:0]   rise_w;
  logic [GXIP_NPINS:0]   fall_w;
  logic [GXIP_NPINS:0]   sync_w;
  assign raw_in = {nmi_pin, gpio_bank_zero_i};

  genvar gi;
  generate
    for (gi = 0; gi <= GXIP_NPINS; gi++)
    begin : g_sync
      gxip_sync_edge u_se (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .pin_in  (raw_in[gi]),
        .eo      (e_if[gi])
      );
      assign rise_w[gi] = e_if[gi].rise;
      assign fall_w[gi] = e_if[gi].fall;
      assign sync_w[gi] = e_if[gi].pin_sync;
    end
  endgenerate

  // apb decode; zero wait states, every access completes in its access phase
  wire                 acc     = psel & penable;
  wire                 wr_acc  = acc & pwrite;
  wire                 rd_acc  = acc & ~pwrite;
  wire                 hit_dir  = (paddr == GXIP_OFF_DIR);
  wire                 hit_out  = (paddr == GXIP_OFF_OUT);
  wire                 hit_in   = (paddr == GXIP_OFF_IN);
  wire                 hit_ien  = (paddr == GXIP_OFF_IEN);
  wire                 hit_pol  = (paddr == GXIP_OFF_POL);
  wire                 hit_mux  = (paddr == GXIP_OFF_MUX);
  wire                 hit_stat = (paddr == GXIP_OFF_STAT);
  wire                 hit_mask = (paddr == GXIP_OFF_MASK);
  wire                 hit_any  = hit_dir | hit_out | hit_in | hit_ien | hit_pol |
                                  hit_mux | hit_stat | hit_mask;
  wire [31:0]          rd_mux =
      hit_dir  ? {24'h000000, dir_reg} :
      hit_out  ? {24'h000000, out_reg} :
      hit_in   ? {24'h000000, sync_w[7:0]} :
      hit_ien  ? {24'h000000, ien_reg, 4'h0} :
      hit_pol  ? {28'h0000000, pol_reg} :
      hit_mux  ? {28'h0000000, mux_reg} :
      hit_stat ? {23'h000000, stat_reg} :
      hit_mask ? {23'h000000, mask_reg} : 32'h00000000;

  // pin mode decode
  wire [1:0]           p0_mode = mux_reg[GXIP_MUX_P0_LO+1:GXIP_MUX_P0_LO];
  wire                 p1_gpio = mux_reg[GXIP_MUX_P1_GPIO];
  wire                 p2_gpio = mux_reg[GXIP_MUX_P2_GPIO];

  // per-pin edge pick: polarity 0 rising, 1 falling
  wire [7:4]           ext_edge = (rise_w[7:4] & ~pol_reg) |
                                  (fall_w[7:4] & pol_reg);
  wire [7:4]           ext_evt  = ext_edge & ien_reg;
  wire                 nmi_evt  = rise_w[GXIP_NPINS];

  // write one clears, a new event in the same cycle wins
  wire [GXIP_STAT_W-1:0] set_v = {nmi_evt, ext_evt, 4'h0};
  wire [GXIP_STAT_W-1:0] clr_v = (wr_acc & hit_stat) ? pwdata[GXIP_STAT_W-1:0] :
                                                       {GXIP_STAT_W{1'b0}};
  assign stat_next = (stat_reg & ~clr_v) | set_v;

  // divided clock terminal counts
  wire                 cnt4_wrap = (cnt4_reg == 2'(GXIP_DIV_QUARTER - 1));
  wire                 cnt6_wrap = (cnt6_reg == 3'(GXIP_DIV_SIXTH - 1));

  // interrupt level; pin 0 in irq mode carries it in step with irq
  wire                 irq_lvl  = |(stat_reg & mask_reg);

  // next pin drive; interrupt pins and pin 0 input mode never drive
  logic [7:0] oe_next;
  logic [7:0] o_next;
  always_comb
  begin
    oe_next = dir_reg;
    o_next  = out_reg;
    oe_next[7:4] = dir_reg[7:4] & ~ien_reg;
    unique case (p0_mode)
      GXIP_P0_GPOUT: begin oe_next[0] = 1'b1; o_next[0] = out_reg[0]; end
      GXIP_P0_IRQ:   begin oe_next[0] = 1'b1; o_next[0] = irq_lvl;    end
      default:       begin oe_next[0] = 1'b0; o_next[0] = 1'b0;       end
    endcase
    if (!p1_gpio)
    begin
      oe_next[1] = 1'b1;
      o_next[1]  = clk4_reg;
    end
    if (!p2_gpio)
    begin
      oe_next[2] = 1'b1;
      o_next[2]  = clk6_reg;
    end
  end

  // apb response registers
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // configuration registers, written at the completing edge
  wire wr_done = wr_acc & pready & ce;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      dir_reg  <= GXIP_DIR_RST;
      out_reg  <= GXIP_OUT_RST;
      ien_reg  <= 4'h0;
      pol_reg  <= GXIP_POL_RST;
      mux_reg  <= GXIP_MUX_RST;
      mask_reg <= {GXIP_STAT_W{1'b0}};
    end
    else if (wr_done)
    begin
      if (hit_dir)  dir_reg  <= pwdata[7:0];
      if (hit_out)  out_reg  <= pwdata[7:0];
      if (hit_ien)  ien_reg  <= pwdata[7:4];
      if (hit_pol)  pol_reg  <= pwdata[3:0];
      if (hit_mux)  mux_reg  <= pwdata[3:0];
      if (hit_mask) mask_reg <= pwdata[GXIP_STAT_W-1:0];
    end
  end

  // status; clear only counted on the completing edge
  wire [GXIP_STAT_W-1:0] stat_upd = pready ? stat_next : (stat_reg | set_v);
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      stat_reg <= {GXIP_STAT_W{1'b0}};
    else if (ce)
      stat_reg <= stat_upd;
  end

  // divided clocks: 50 % duty, quarter and sixth of core rate
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt4_reg <= 2'h0;
      cnt6_reg <= 3'h0;
      clk4_reg <= 1'b0;
      clk6_reg <= 1'b0;
    end
    else if (ce)
    begin
      cnt4_reg <= cnt4_wrap ? 2'h0 : cnt4_reg + 2'h1;
      cnt6_reg <= cnt6_wrap ? 3'h0 : cnt6_reg + 3'h1;
      clk4_reg <= (cnt4_reg < 2'(GXIP_DIV_QUARTER / 2)) ? 1'b0 : 1'b1;
      clk6_reg <= (cnt6_reg < 3'(GXIP_DIV_SIXTH / 2)) ? 1'b0 : 1'b1;
    end
  end

  // pin drivers and interrupt outputs, all registered
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      gpio_bank_zero_o  <= 8'h00;
      gpio_bank_zero_oe <= 8'h00;
      nmi_event         <= 1'b0;
      irq               <= 1'b0;
    end
    else if (ce)
    begin
      gpio_bank_zero_o  <= o_next;
      gpio_bank_zero_oe <= oe_next;
      irq               <= irq_lvl;
      nmi_event         <= nmi_evt;
    end
  end
endmodule : gxip_top

// *** gxip_top_monitor.sv ***
// port-level checks for the gpio and interrupt pin block
`timescale 1ns/1ns
module gxip_top_monitor (
  input wire logic        clk_sys,           // core clock
  input wire logic        rstn,              // reset, active low
  input wire logic        psel,              // select
  input wire logic        penable,           // access phase
  input wire logic        pwrite,            // write
  input wire logic [11:0] paddr,             // address
  input wire logic [31:0] pwdata,            // write data
  input wire logic [31:0] prdata,            // read data
  input wire logic        pready,            // done
  input wire logic        pslverr,           // error
  input wire logic [7:0]  gpio_bank_zero_o,  // drive values
  input wire logic [7:0]  gpio_bank_zero_oe, // drive enables
  input wire logic        nmi_pin,           // nmi pin
  input wire logic        nmi_event,         // nmi pulse
  input wire logic        irq                // interrupt level
);
  logic [3:0] m_q;
  logic [7:0] ien_q;
  wire        wr = psel && penable && pready && pwrite;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // shadows of mux and enable: mux lets clock checks stand down once a pin turns gpio, enable gates the interrupt pin check
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      m_q   <= 4'h0;
      ien_q <= 8'h00;
    end
    else if (wr && paddr == 12'h014)
      m_q <= pwdata[3:0];
    else if (wr && paddr == 12'h00c)
      ien_q <= pwdata[7:0];
  a_nmi_level_quiet: assert property ((!nmi_pin)[*6] |-> !nmi_event)
    else $error("nmi pulse without rising edge");
  a_nmi_one_pulse: assert property (nmi_event |=> !nmi_event)
    else $error("nmi pulse longer than one cycle");
  a_reset_oe_off: assert property (disable iff (1'b0) !rstn |-> gpio_bank_zero_oe == 8'h00)
    else $error("pin driven during reset");
  a_quarter_clk: assert property ($rose(gpio_bank_zero_o[1]) && !m_q[0] |->
    (gpio_bank_zero_o[1][*2] ##1 !gpio_bank_zero_o[1][*2]) or (##[0:3] m_q[0]))
    else $error("pin 1 clock period wrong");
  a_sixth_clk: assert property ($rose(gpio_bank_zero_o[2]) && !m_q[1] |->
    (gpio_bank_zero_o[2][*3] ##1 !gpio_bank_zero_o[2][*3]) or (##[0:4] m_q[1]))
    else $error("pin 2 clock period wrong");
  a_irq_in_only: assert property ((gpio_bank_zero_oe[7:4] & ien_q[7:4] & $past(ien_q[7:4])) == 4'h0)
    else $error("interrupt pin driven");
  a_pin0_irq_out: assert property (m_q[3] && !m_q[2] && $past(m_q) == m_q |->
    gpio_bank_zero_oe[0] && gpio_bank_zero_o[0] == irq)
    else $error("pin 0 not carrying interrupt");
  a_apb_no_wait: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not in access cycle");
  a_unmapped_err: assert property (pready && paddr > 12'h01c |-> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");
endmodule : gxip_top_monitor

// *** gxip_board_model.sv ***
// board side of the pins: pulls, external drivers, pin 0 held low in reset
`timescale 1ns/1ns
module gxip_board_model (
  input  wire logic       rstn,    // device reset
  input  wire logic [7:0] pin_o,   // device drive values
  input  wire logic [7:0] pin_oe,  // device drive enables
  input  wire logic [7:0] drv_val, // board drive values
  input  wire logic [7:0] drv_en,  // board drive enables
  output logic      [7:0] pin_i    // resolved levels
);
  localparam logic [7:0] PULL_UP = 8'hf6; // pins 0 and 3 pulled down
  logic [7:0] lvl;
  // device wins, then board driver, then the resistor
  assign lvl   = (pin_oe & pin_o) | (~pin_oe & drv_en & drv_val) | (~pin_oe & ~drv_en & PULL_UP);
  assign pin_i = rstn ? lvl : (lvl & 8'hfe);
endmodule : gxip_board_model

// *** test_gxip_top.sv ***
// self-checking bench for the gpio and interrupt pin block
`timescale 1ns/1ns
module test_gxip_top;
  import gxip_pkg::*;
  logic        clk_sys, rstn, psel, penable, pwrite, nmi_pin, pready, pslverr, nmi_event, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  pin_i, pin_o, pin_oe, drv_val, drv_en, p;
  int          miscompares = 0, n_tests = 0, n_nmi = 0, r1, r2;
  gxip_top uut (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_bank_zero_i(pin_i), .gpio_bank_zero_o(pin_o),
    .gpio_bank_zero_oe(pin_oe), .nmi_pin(nmi_pin), .nmi_event(nmi_event), .irq(irq));
  gxip_board_model board (.rstn(rstn), .pin_o(pin_o), .pin_oe(pin_oe), .drv_val(drv_val),
    .drv_en(drv_en), .pin_i(pin_i));
  // core clock, 8 ns
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // count nmi pulses seen by the core
  always @(posedge clk_sys)
    if (nmi_event === 1'b1)
      n_nmi++;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, request held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // look at pready mid-cycle, then complete on the rising edge that samples it
    @(negedge clk_sys);
    while (pready !== 1'b1)
      @(negedge clk_sys);
    rd      = prdata;
    err     = pslverr;
    @(posedge clk_sys);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task results;
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // watchdog against a hung handshake
  initial
  begin
    #100000;
    miscompares++;
    results();
  end
  // main sequence
  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    nmi_pin = 1'b0;
    drv_en = 8'hf0;
    drv_val = 8'hf0;
    p = 8'h0;
    r1 = 0;
    r2 = 0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(pin_oe, 8'h06);
    // toggles over 24 cycles: every 2 for quarter rate, every 3 for sixth rate
    repeat (24)
    begin
      @(posedge clk_sys);
      r1 += int'(pin_o[1] ^ p[1]);
      r2 += int'(pin_o[2] ^ p[2]);
      p = pin_o;
    end
    chk(r1 - int'(p[1] ^ 1'b0) * 0, 12);
    chk(r2, 8);
    rdc(GXIP_OFF_DIR, 32'h0);
    rdc(GXIP_OFF_MUX, 32'h0);
    rdc(GXIP_OFF_POL, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({err, rd}, 33'h100000000);
    apb(1'b1, GXIP_OFF_MASK, 32'h1ff);
    nmi_pin <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rdc(GXIP_OFF_STAT, 32'h100);
    chk(irq, 1'b1);
    apb(1'b1, GXIP_OFF_STAT, 32'h100);
    nmi_pin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk({irq, n_nmi[3:0]}, 5'h01);
    apb(1'b1, GXIP_OFF_IEN, 32'hf0);
    apb(1'b1, GXIP_OFF_POL, 32'ha);
    drv_val <= 8'h00;
    repeat (8) @(posedge clk_sys);
    rdc(GXIP_OFF_STAT, 32'h0a0);
    apb(1'b1, GXIP_OFF_STAT, 32'h1ff);
    apb(1'b1, GXIP_OFF_IEN, 32'h70);
    apb(1'b1, GXIP_OFF_POL, 32'h2);
    drv_val <= 8'hf0;
    repeat (8) @(posedge clk_sys);
    rdc(GXIP_OFF_STAT, 32'h050);
    apb(1'b1, GXIP_OFF_MUX, 32'h4);
    apb(1'b1, GXIP_OFF_OUT, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk({pin_oe[0], pin_o[0]}, 2'b11);
    apb(1'b1, GXIP_OFF_STAT, 32'h1ff);
    apb(1'b1, GXIP_OFF_MUX, 32'h8);
    repeat (3) @(posedge clk_sys);
    chk({pin_oe[0], pin_o[0], irq}, 3'b100);
    drv_val <= 8'hb0;
    repeat (4) @(posedge clk_sys);
    drv_val <= 8'hf0;
    repeat (8) @(posedge clk_sys);
    chk({pin_oe[0], pin_o[0], irq}, 3'b111);
    apb(1'b1, GXIP_OFF_STAT, 32'h1ff);
    apb(1'b1, GXIP_OFF_MUX, 32'h3);
    apb(1'b1, GXIP_OFF_DIR, 32'h04);
    apb(1'b1, GXIP_OFF_OUT, 32'h04);
    drv_en <= 8'hf2;
    repeat (6) @(posedge clk_sys);
    rdc(GXIP_OFF_IN, 32'hf4);
    apb(1'b1, GXIP_OFF_DIR, 32'hff);
    repeat (3) @(posedge clk_sys);
    chk(pin_oe, 8'h8e);
    results();
  end
endmodule : test_gxip_top
bind gxip_top gxip_top_monitor mon (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .gpio_bank_zero_o(gpio_bank_zero_o),
  .gpio_bank_zero_oe(gpio_bank_zero_oe), .nmi_pin(nmi_pin), .nmi_event(nmi_event), .irq(irq));
